/* File: rtl/ctg_pkg.sv */
// Shared constants and types for the capture, trigger and timing block
package ctg_pkg;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = DATA_W + 1;
  localparam int FREQ_W = 36;
  localparam int MAG_W = 16;
  localparam int QSR_W = 16;
  localparam int QSR_GNSS_BIT = 9;
  localparam logic [31:0] MIN_CAPTURE = 32'h0000_0080;
  localparam logic [31:0] STORE_ZIF = 32'h0200_0000;
  localparam logic [31:0] STORE_SH = 32'h0400_0000;
  localparam logic signed [15:0] OFFSET_FACTORY_NS = 16'sh0032;
  localparam logic [31:0] POS_INVALID = 32'h7fff_ffff;
  // Clock and derived timing
  localparam int CLK_PERIOD_NS = 20;
  localparam logic signed [15:0] CLK_PERIOD_NS_S = 16'sh0014;
  localparam int ONE_SECOND_NS = 1_000_000_000;
  localparam int ONE_SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
  localparam int FLASH_HALF_MS = 500;
  localparam int FLASH_CYCLES = FLASH_HALF_MS * 1_000_000 / CLK_PERIOD_NS;
  // Constellation mask bits and report codes
  localparam int CONST_GPS = 0;
  localparam int CONST_BEIDOU = 1;
  localparam int CONST_GLONASS = 2;
  localparam logic [2:0] CONST_FACTORY = 3'h5;
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_GPS = 2'h1;
  localparam logic [1:0] CODE_BEIDOU = 2'h2;
  localparam logic [1:0] CODE_GLONASS = 2'h3;
  typedef enum logic [5:0] {
    TRIG_NONE = 6'h01,
    TRIG_LEVEL = 6'h02,
    TRIG_PERIODIC = 6'h04,
    TRIG_PPS = 6'h08,
    TRIG_PULSE = 6'h10,
    TRIG_WORD = 6'h20
  } ctg_trig_t;
  typedef enum logic [3:0] {
    MODE_ZIF = 4'h1,
    MODE_SH = 4'h2,
    MODE_HDR = 4'h4,
    MODE_DD = 4'h8
  } ctg_mode_t;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_ARMED = 4'h2,
    SEQ_CAPTURE = 4'h4,
    SEQ_TRAILER = 4'h8
  } ctg_seq_t;
endpackage : ctg_pkg

/* File: rtl/ctg_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
module ctg_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1))
    begin
      return '0;
    end
    return p + 1'b1;
  endfunction : nextPtr

  assign inReady = count_q != (AW + 1)'(DEPTH);
  assign outValid = count_q != '0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_q];

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= nextPtr(wrPtr_q);
      end
      if (pop)
      begin
        rdPtr_q <= nextPtr(rdPtr_q);
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : ctg_fifo

/* File: rtl/ctg_capture_trigger.sv */
// Capture sequencer, trigger selection and satellite timing status
// Summary of operation
// R1: Trigger type none disables the engine, others enable it; none after reset.
// R2: Pulse and word triggers both take the external trigger input pin.
// R3: Each one-second pulse starts a capture; host keeps captures under one second.
// R4: Level trigger fires when any in-range sample exceeds the amplitude threshold.
// R5: Window holds every bin whose centre lies between start and stop.
// R6: Limits past the usable bandwidth are accepted; only bins inside it count.
// R7: No triggering in high dynamic range or direct digitization modes.
// R8: Each captured data word is 32 bits; layout follows the input mode.
// R9: A capture holds at least 128 samples, at most the store capacity.
// R10: Block capture takes packet size times packet count continuous samples.
// R11: Streaming packets stay continuous until a trailer shows sample loss.
// R12: Loss flag means overflow after that packet; the packet itself is whole. A sample dropped inside the packet is also flagged on its trailer.
// R13: Store holds 32 mega-samples in zero-IF, 64 in superheterodyne mode.
// R14: Timing pulse shifts by a signed 16-bit nanosecond offset.
// R15: Offset defaults to 50 ns, kept over power cycles, untouched by reset command.
// R16: At most two constellations; reported as GPS, BEIDOU, GLONASS order.
// R17: Without a fix, position reads the 7fff_ffff invalid encoding.
// R18: Reference reports disciplining with a fix, holdover without; always valid.
// R19: Questionable status bit 9 is set without a fix, clear with one.
// R20: With this reference selected, indicator flashes green with fix, yellow without.
module ctg_capture_trigger #(
  parameter int ONE_SECOND_CYCLES = ctg_pkg::ONE_SECOND_CYCLES,
  parameter int FLASH_CYCLES = ctg_pkg::FLASH_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Host commands
  input wire logic resetCmd,
  input wire logic captureAbort,
  input wire logic trigTypeWrite,
  input wire ctg_pkg::ctg_trig_t trigTypeSel,
  input wire ctg_pkg::ctg_mode_t inputMode,
  input wire logic blockStart,
  input wire logic streamStart,
  input wire logic streamStop,
  input wire logic [15:0] samplesPerPacket,
  input wire logic [15:0] packetCount,
  // Level trigger setup and spectrum bins
  input wire logic [ctg_pkg::FREQ_W-1:0] levelStartHz,
  input wire logic [ctg_pkg::FREQ_W-1:0] levelStopHz,
  input wire logic [ctg_pkg::FREQ_W-1:0] bandLoHz,
  input wire logic [ctg_pkg::FREQ_W-1:0] bandHiHz,
  input wire logic signed [ctg_pkg::MAG_W-1:0] levelThreshold,
  input wire logic binValid,
  input wire logic [ctg_pkg::FREQ_W-1:0] binCentreHz,
  input wire logic signed [ctg_pkg::MAG_W-1:0] binMagnitude,
  // External trigger pins
  input wire logic external_trigger_input,
  input wire logic [7:0] extWordIn,
  input wire logic [7:0] trigWordMatch,
  input wire logic one_second_pulse,
  // Sample input
  input wire logic sampleValid,
  input wire logic [ctg_pkg::DATA_W-1:0] sampleData,
  // Packet output
  output logic outValid,
  input wire logic outReady,
  output logic [ctg_pkg::DATA_W-1:0] outData,
  output logic outTrailer,
  // Capture status
  output logic captureBusy,
  output logic captureArmed,
  output logic trigEnabled,
  // Satellite receiver side
  input wire logic gnssFix,
  input wire logic utcPulseIn,
  input wire logic [31:0] latIn,
  input wire logic [31:0] lonIn,
  input wire logic [31:0] altIn,
  input wire logic pllRefIsGnss,
  // Timing pulse offset
  input wire logic offsetWrite,
  input wire logic signed [15:0] offsetData,
  input wire logic nvLoad,
  input wire logic signed [15:0] nvOffset,
  output logic signed [15:0] timing_pulse_offset,
  output logic timingPulseOut,
  // Constellation selection
  input wire logic constSet,
  input wire logic [2:0] constReq,
  output logic constReject,
  output logic [1:0] constFirst,
  output logic [1:0] constSecond,
  // Timing status
  output logic refDisciplined,
  output logic refHoldover,
  output logic refValid,
  output logic [ctg_pkg::QSR_W-1:0] questionable_status_register,
  output logic [31:0] posLat,
  output logic [31:0] posLon,
  output logic [31:0] posAlt,
  output logic ledGreen,
  output logic ledYellow
);
  ctg_pkg::ctg_trig_t trigType_q;
  ctg_pkg::ctg_seq_t state_q;
  logic extPrev_q, ppsPrev_q, utcPrev_q;
  logic streamMode_q, stopReq_q, lossPending_q;
  logic [15:0] spp_q, pktCnt_q;
  logic [31:0] total_q, totCnt_q;
  logic [31:0] secCnt_q, flashCnt_q;
  logic flashOn_q;
  logic [2:0] constMask_q;
  logic levelHit, trigFire, trigBlocked;
  logic sampleWr, trailerWr, sampleDrop, lossFlag, pktEnd;
  logic fifoInValid, fifoInReady;
  logic [ctg_pkg::FIFO_W-1:0] fifoInData, fifoOutData;
  logic signed [15:0] offCycles;
  logic [31:0] pulseTarget;

  function automatic logic inRange(input logic [ctg_pkg::FREQ_W-1:0] f,
                                   input logic [ctg_pkg::FREQ_W-1:0] lo,
                                   input logic [ctg_pkg::FREQ_W-1:0] hi);
    return (f >= lo) && (f <= hi);
  endfunction : inRange

  function automatic logic rise(input logic cur, input logic prev);
    return cur && !prev;
  endfunction : rise

  function automatic logic [31:0] clampTotal(input logic [31:0] want,
                                             input ctg_pkg::ctg_mode_t mode);
    logic [31:0] cap;
    cap = (mode == ctg_pkg::MODE_ZIF) ? ctg_pkg::STORE_ZIF : ctg_pkg::STORE_SH; // R13
    if (want < ctg_pkg::MIN_CAPTURE)
    begin
      return ctg_pkg::MIN_CAPTURE; // R9
    end
    if (want > cap)
    begin
      return cap; // R9
    end
    return want;
  endfunction : clampTotal

  function automatic logic [1:0] popCount(input logic [2:0] m);
    return 2'(m[0]) + 2'(m[1]) + 2'(m[2]);
  endfunction : popCount

  // Trigger selection
  assign trigBlocked = (inputMode == ctg_pkg::MODE_HDR) || (inputMode == ctg_pkg::MODE_DD); // R7
  assign trigEnabled = (trigType_q != ctg_pkg::TRIG_NONE) && !trigBlocked; // R1 R7
  // Out-of-band limits are accepted as given; the band check just masks bins
  assign levelHit = binValid && inRange(binCentreHz, levelStartHz, levelStopHz) // R5
    && inRange(binCentreHz, bandLoHz, bandHiHz) // R6
    && (binMagnitude > levelThreshold); // R4

  always_comb
  begin
    trigFire = 1'b0;
    case (trigType_q)
      ctg_pkg::TRIG_LEVEL: trigFire = levelHit; // R4
      ctg_pkg::TRIG_PULSE: trigFire = rise(external_trigger_input, extPrev_q); // R2
      ctg_pkg::TRIG_WORD: trigFire = rise(external_trigger_input, extPrev_q)
        && (extWordIn == trigWordMatch); // R2
      ctg_pkg::TRIG_PPS: trigFire = rise(one_second_pulse, ppsPrev_q); // R3
      default: trigFire = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      trigType_q <= ctg_pkg::TRIG_NONE; // R1
    end
    else if (resetCmd)
    begin
      trigType_q <= ctg_pkg::TRIG_NONE; // R1
    end
    else if (trigTypeWrite && state_q == ctg_pkg::SEQ_IDLE)
    begin
      trigType_q <= trigTypeSel;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      extPrev_q <= 1'b0;
      ppsPrev_q <= 1'b0;
      utcPrev_q <= 1'b0;
    end
    else
    begin
      extPrev_q <= external_trigger_input;
      ppsPrev_q <= one_second_pulse;
      utcPrev_q <= utcPulseIn;
    end
  end

  // Capture datapath into the FIFO
  assign pktEnd = (pktCnt_q == spp_q - 16'h0001)
    || (!streamMode_q && totCnt_q == total_q - 32'h0000_0001); // R10
  assign sampleWr = (state_q == ctg_pkg::SEQ_CAPTURE) && sampleValid && fifoInReady; // R8
  assign trailerWr = (state_q == ctg_pkg::SEQ_TRAILER) && fifoInReady;
  // A sample arriving while the trailer is pending is lost after this packet
  assign sampleDrop = sampleValid && !sampleWr
    && ((state_q == ctg_pkg::SEQ_CAPTURE) || (state_q == ctg_pkg::SEQ_TRAILER));
  assign lossFlag = lossPending_q || (sampleValid && state_q == ctg_pkg::SEQ_TRAILER); // R12
  assign fifoInValid = sampleWr || trailerWr;
  assign fifoInData = trailerWr ? {1'b1, 31'h0000_0000, lossFlag} : {1'b0, sampleData}; // R11
  assign captureBusy = state_q != ctg_pkg::SEQ_IDLE;
  assign captureArmed = state_q == ctg_pkg::SEQ_ARMED;

  // Capture sequencer
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ctg_pkg::SEQ_IDLE;
      streamMode_q <= 1'b0;
      stopReq_q <= 1'b0;
      spp_q <= 16'h0001;
      total_q <= ctg_pkg::MIN_CAPTURE;
      totCnt_q <= '0;
      pktCnt_q <= '0;
    end
    else if (resetCmd || captureAbort)
    begin
      state_q <= ctg_pkg::SEQ_IDLE;
      stopReq_q <= 1'b0;
    end
    else
    begin
      if (streamStop)
      begin
        stopReq_q <= 1'b1;
      end
      case (state_q)
        ctg_pkg::SEQ_IDLE:
        begin
          if (blockStart || streamStart)
          begin
            streamMode_q <= streamStart;
            stopReq_q <= 1'b0;
            spp_q <= (samplesPerPacket == 16'h0000) ? 16'h0001 : samplesPerPacket;
            total_q <= clampTotal({16'h0000, samplesPerPacket} * {16'h0000, packetCount},
                                  inputMode); // R10 R9
            totCnt_q <= '0;
            pktCnt_q <= '0;
            state_q <= trigEnabled ? ctg_pkg::SEQ_ARMED : ctg_pkg::SEQ_CAPTURE; // R1
          end
        end
        ctg_pkg::SEQ_ARMED:
        begin
          if (!trigEnabled || trigFire)
          begin
            state_q <= ctg_pkg::SEQ_CAPTURE; // R3 R4
          end
        end
        ctg_pkg::SEQ_CAPTURE:
        begin
          if (sampleWr)
          begin
            totCnt_q <= totCnt_q + 32'h0000_0001;
            if (pktEnd)
            begin
              pktCnt_q <= '0;
              state_q <= ctg_pkg::SEQ_TRAILER;
            end
            else
            begin
              pktCnt_q <= pktCnt_q + 16'h0001;
            end
          end
        end
        ctg_pkg::SEQ_TRAILER:
        begin
          if (trailerWr)
          begin
            if (!streamMode_q && totCnt_q == total_q)
            begin
              totCnt_q <= '0;
              // One-second trigger re-arms so each pulse starts a new block
              state_q <= (trigEnabled && trigType_q == ctg_pkg::TRIG_PPS)
                ? ctg_pkg::SEQ_ARMED : ctg_pkg::SEQ_IDLE; // R3
            end
            else if (streamMode_q && (stopReq_q || streamStop))
            begin
              state_q <= ctg_pkg::SEQ_IDLE;
            end
            else
            begin
              state_q <= ctg_pkg::SEQ_CAPTURE; // R11
            end
          end
        end
        default: state_q <= ctg_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Loss reported on the trailer; a drop in the trailer cycle rides on that trailer
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      lossPending_q <= 1'b0;
    end
    else if (trailerWr || state_q == ctg_pkg::SEQ_IDLE)
    begin
      lossPending_q <= 1'b0; // R12
    end
    else if (sampleDrop)
    begin
      lossPending_q <= 1'b1; // R11
    end
  end

  ctg_fifo #(
    .WIDTH(ctg_pkg::FIFO_W),
    .DEPTH(ctg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(outValid),
    .outReady(outReady),
    .outData(fifoOutData)
  );

  assign outData = fifoOutData[ctg_pkg::DATA_W-1:0];
  assign outTrailer = fifoOutData[ctg_pkg::DATA_W];

  // Timing pulse offset, kept apart from the reset command
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      timing_pulse_offset <= ctg_pkg::OFFSET_FACTORY_NS; // R15
    end
    else if (offsetWrite)
    begin
      timing_pulse_offset <= offsetData; // R14
    end
    else if (nvLoad)
    begin
      timing_pulse_offset <= nvOffset; // R15
    end
  end

  // Resolution is one clock period; sub-period offsets truncate toward zero
  assign offCycles = timing_pulse_offset / ctg_pkg::CLK_PERIOD_NS_S;
  assign pulseTarget = (timing_pulse_offset < 0 ? 32'(ONE_SECOND_CYCLES) : 32'h0000_0000)
    + {{16{offCycles[15]}}, offCycles}; // R14

  // Free-running second counter keeps the pulse going through holdover
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      secCnt_q <= '0;
      timingPulseOut <= 1'b0;
    end
    else
    begin
      if (rise(utcPulseIn, utcPrev_q) || secCnt_q == 32'(ONE_SECOND_CYCLES - 1))
      begin
        secCnt_q <= '0;
      end
      else
      begin
        secCnt_q <= secCnt_q + 32'h0000_0001;
      end
      timingPulseOut <= secCnt_q == pulseTarget; // R14
    end
  end

  // Constellation selection, not touched by the reset command
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      constMask_q <= ctg_pkg::CONST_FACTORY;
      constReject <= 1'b0;
      constFirst <= ctg_pkg::CODE_NONE;
      constSecond <= ctg_pkg::CODE_NONE;
    end
    else
    begin
      constReject <= constSet && (popCount(constReq) == 2'h0 || popCount(constReq) == 2'h3);
      if (constSet && popCount(constReq) != 2'h0 && popCount(constReq) != 2'h3)
      begin
        constMask_q <= constReq; // R16
      end
      constFirst <= constMask_q[ctg_pkg::CONST_GPS] ? ctg_pkg::CODE_GPS
        : constMask_q[ctg_pkg::CONST_BEIDOU] ? ctg_pkg::CODE_BEIDOU
        : constMask_q[ctg_pkg::CONST_GLONASS] ? ctg_pkg::CODE_GLONASS : ctg_pkg::CODE_NONE; // R16
      constSecond <= popCount(constMask_q) != 2'h2 ? ctg_pkg::CODE_NONE
        : constMask_q[ctg_pkg::CONST_GLONASS] ? ctg_pkg::CODE_GLONASS : ctg_pkg::CODE_BEIDOU; // R16
    end
  end

  // Fix-dependent status and position
  assign refValid = 1'b1; // R18
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      refDisciplined <= 1'b0;
      refHoldover <= 1'b1;
      questionable_status_register <= '0;
      posLat <= ctg_pkg::POS_INVALID;
      posLon <= ctg_pkg::POS_INVALID;
      posAlt <= ctg_pkg::POS_INVALID;
    end
    else
    begin
      refDisciplined <= gnssFix; // R18
      refHoldover <= !gnssFix; // R18
      questionable_status_register <= '0;
      questionable_status_register[ctg_pkg::QSR_GNSS_BIT] <= !gnssFix; // R19
      posLat <= gnssFix ? latIn : ctg_pkg::POS_INVALID; // R17
      posLon <= gnssFix ? lonIn : ctg_pkg::POS_INVALID; // R17
      posAlt <= gnssFix ? altIn : ctg_pkg::POS_INVALID; // R17
    end
  end

  // Indicator flash
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      flashCnt_q <= '0;
      flashOn_q <= 1'b0;
      ledGreen <= 1'b0;
      ledYellow <= 1'b0;
    end
    else
    begin
      if (flashCnt_q == 32'(FLASH_CYCLES - 1))
      begin
        flashCnt_q <= '0;
        flashOn_q <= !flashOn_q;
      end
      else
      begin
        flashCnt_q <= flashCnt_q + 32'h0000_0001;
      end
      ledGreen <= pllRefIsGnss && gnssFix && flashOn_q; // R20
      ledYellow <= pllRefIsGnss && !gnssFix && flashOn_q; // R20
    end
  end

  // Checks
  trig_none_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
    resetCmd |=> !trigEnabled)
    else $error("trigger still enabled after reset command");
  trig_mode_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
    (inputMode == ctg_pkg::MODE_HDR || inputMode == ctg_pkg::MODE_DD) |-> !trigEnabled)
    else $error("trigger enabled in a mode without triggering");
  ext_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
    (state_q == ctg_pkg::SEQ_ARMED && trigEnabled && trigType_q == ctg_pkg::TRIG_PULSE
     && !resetCmd && !captureAbort && external_trigger_input && !extPrev_q)
    |=> state_q == ctg_pkg::SEQ_CAPTURE)
    else $error("external pulse did not start capture");
  pps_start_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
    (state_q == ctg_pkg::SEQ_ARMED && trigEnabled && trigType_q == ctg_pkg::TRIG_PPS
     && !resetCmd && !captureAbort && $rose(one_second_pulse))
    |=> state_q == ctg_pkg::SEQ_CAPTURE)
    else $error("one-second pulse did not start capture");
  band_mask_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
    (binValid && !inRange(binCentreHz, bandLoHz, bandHiHz)) |-> !levelHit)
    else $error("bin outside usable band fired the level trigger");
  total_min_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
    captureBusy |-> (total_q >= ctg_pkg::MIN_CAPTURE && total_q <= ctg_pkg::STORE_SH))
    else $error("capture length outside limits");
  loss_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
    (sampleDrop && state_q == ctg_pkg::SEQ_CAPTURE && !resetCmd && !captureAbort)
    |=> lossFlag)
    else $error("dropped sample not held for the trailer");
  qsr_fix_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R19
    $rose(gnssFix) |=> !questionable_status_register[ctg_pkg::QSR_GNSS_BIT] [*1])
    else $error("status bit 9 not cleared with fix");
  pos_invalid_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R17
    !gnssFix |=> (posLat == ctg_pkg::POS_INVALID && posAlt == ctg_pkg::POS_INVALID))
    else $error("position not invalid without fix");
  const_order_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
    constSecond != ctg_pkg::CODE_NONE |-> constFirst < constSecond)
    else $error("constellations out of order");
  offset_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
    (resetCmd && !offsetWrite && !nvLoad) |=> $stable(timing_pulse_offset))
    else $error("reset command changed the pulse offset");
  block_done_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    trailerWr && !streamMode_q && totCnt_q == total_q);
  stream_loss_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    trailerWr && streamMode_q && lossFlag);
  level_fire_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_q == ctg_pkg::SEQ_ARMED && trigType_q == ctg_pkg::TRIG_LEVEL && levelHit);
  pps_rearm_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    trailerWr && trigType_q == ctg_pkg::TRIG_PPS ##1 state_q == ctg_pkg::SEQ_ARMED);
endmodule : ctg_capture_trigger

/* File: testbench/ctg_sample_src.sv */
// Sample source feeding the capture path
module ctg_sample_src (
  // Clock and control
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [31:0] base,
  // Samples
  output logic sampleValid,
  output logic [31:0] sampleData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] n;
  initial sampleValid = 1'b0;
  // A gap after every sample keeps each trailer cycle free of data
  // Controls are read at the edge, ahead of the bench's own updates
  always @(posedge clk_sys)
  begin
    n <= #1 run ? n + 32'(sampleValid) : base;
    sampleValid <= #1 run && !sampleValid;
  end
  // Idle data is inverted so a stale word never passes for a sample
  assign sampleData = sampleValid ? n : ~n;
endmodule : ctg_sample_src

/* File: testbench/ctg_capture_trigger_test.sv */
// Self-checking bench for the capture, trigger and timing block
module ctg_capture_trigger_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, resetn = 0, resetCmd = 0, captureAbort = 0, trigTypeWrite = 0;
  logic blockStart = 0, streamStart = 0, streamStop = 0, binValid = 0, gnssFix = 0;
  logic external_trigger_input = 0, one_second_pulse = 0, outReady = 1, utcPulseIn = 0;
  logic pllRefIsGnss = 1, offsetWrite = 0, nvLoad = 0, constSet = 0, run = 0;
  logic sampleValid, outValid, outTrailer, captureBusy, captureArmed, trigEnabled;
  logic timingPulseOut, constReject, refDisciplined, refHoldover, refValid, ledGreen, ledYellow;
  ctg_pkg::ctg_trig_t trigTypeSel = ctg_pkg::TRIG_NONE;
  ctg_pkg::ctg_mode_t inputMode = ctg_pkg::MODE_ZIF;
  logic [15:0] samplesPerPacket = 16'h0002, packetCount = 16'h0020;
  logic [35:0] levelStartHz = '0, levelStopHz = '0, bandLoHz = '0;
  logic [35:0] bandHiHz = '0, binCentreHz = '0;
  logic signed [15:0] levelThreshold = '0, binMagnitude = '0, offsetData = '0, nvOffset = '0;
  logic [7:0] extWordIn = '0, trigWordMatch = '0;
  logic [31:0] latIn = '0, lonIn = '0, altIn = '0, base = '0;
  logic [2:0] constReq = '0;
  logic signed [15:0] timing_pulse_offset;
  logic [15:0] questionable_status_register;
  logic [31:0] sampleData, outData, posLat, posLon, posAlt;
  logic [1:0] constFirst, constSecond;
  logic [32:0] expQ[$];
  int fail_count = 0;
  int samples_checked = 0;
  ctg_capture_trigger #(.ONE_SECOND_CYCLES(1000), .FLASH_CYCLES(8)) ctg_capture_trigger_inst (.*);
  ctg_sample_src ctg_sample_src_inst (.*);
  always #10 clk_sys = ~clk_sys;
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d fails %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  task automatic ledScan(input logic [1:0] e);
    logic [1:0] seen;
    seen = '0;
    repeat (16)
    begin
      seen |= {ledGreen, ledYellow};
      tick(1);
    end
    chk(seen, e);
  endtask : ledScan
  // Trailers are judged on the loss flag only
  always @(posedge clk_sys)
    if (outValid && outReady)
      chk(outTrailer ? {1'b1, 31'h0, outData[0]} : {1'b0, outData}, expQ.pop_front());
  initial
  begin
    void'($urandom(99));
    tick(10);
    resetn = 1'b1;
    tick(1);
    chk(trigEnabled, 1'b0);
    chk(timing_pulse_offset, 16'h0032);
    chk(posLat, 32'h7fff_ffff);
    chk(questionable_status_register[9], 1'b1);
    chk({refValid, refHoldover}, 2'h3);
    chk(posAlt, 32'h7fff_ffff);
    $display("reset done");
    for (int i = 0; i < 6; i++)
      for (int m = 0; m < 4; m++)
      begin
        trigTypeSel = ctg_pkg::ctg_trig_t'(6'h01 << i);
        inputMode = ctg_pkg::ctg_mode_t'(4'h1 << m);
        pulse(trigTypeWrite);
        chk(trigEnabled, i > 0 && m < 2);
        tick(1);
      end
    pulse(resetCmd);
    chk(trigEnabled, 1'b0);
    inputMode = ctg_pkg::MODE_ZIF;
    $display("types done");
    // Block of 64 packets, then a stream stopped during its second packet
    for (int s = 0; s < 2; s++)
    begin
      base = $urandom;
      for (int p = 0; p < (s ? 2 : 64); p++)
      begin
        expQ.push_back({1'b0, base + 32'(2 * p)});
        expQ.push_back({1'b0, base + 32'(2 * p + 1)});
        expQ.push_back({1'b1, 32'h0});
      end
      if (s)
        pulse(streamStart);
      else
        pulse(blockStart);
      chk(captureBusy, 1'b1);
      run = 1'b1;
      for (int i = 0; i < 2000 && captureBusy; i++)
      begin
        streamStop = s && i == 6;
        tick(1);
      end
      chk(captureBusy, 1'b0);
      if (captureBusy !== 1'b0)
        test_done();
      run = 1'b0;
      tick(4);
      chk(expQ.size(), 0);
      $display("capture done");
    end
    binMagnitude = 16'sh0001;
    for (int k = 0; k < 4; k++)
    begin
      trigTypeSel = k == 3 ? ctg_pkg::TRIG_LEVEL : ctg_pkg::ctg_trig_t'(6'h08 << k);
      pulse(trigTypeWrite);
      pulse(blockStart);
      chk(captureArmed, 1'b1);
      {binValid, one_second_pulse, external_trigger_input} = k == 3 ? 3'h4 : k ? 3'h1 : 3'h2;
      tick(2);
      chk({captureArmed, captureBusy}, 2'h1);
      {binValid, one_second_pulse, external_trigger_input} = 3'h0;
      pulse(captureAbort);
    end
    offsetData = 16'($urandom);
    pulse(offsetWrite);
    chk(timing_pulse_offset, offsetData);
    pulse(resetCmd);
    chk(timing_pulse_offset, offsetData);
    // 100 ns is five clock periods after the reference edge
    offsetData = 16'sh0064;
    pulse(offsetWrite);
    utcPulseIn = 1'b1;
    tick(6);
    chk(timingPulseOut, 1'b0);
    tick(1);
    chk(timingPulseOut, 1'b1);
    ledScan(2'h1);
    latIn = $urandom;
    gnssFix = 1'b1;
    tick(2);
    chk(questionable_status_register[9], 1'b0);
    chk(refDisciplined, 1'b1);
    chk({refValid, refHoldover}, 2'h2);
    ledScan(2'h2);
    chk(posLat, latIn);
    constReq = 3'h6;
    pulse(constSet);
    tick(1);
    chk({constFirst, constSecond}, 4'hb);
    constReq = 3'h7;
    pulse(constSet);
    chk(constReject, 1'b1);
    $display("timing done");
    test_done();
  end
endmodule : ctg_capture_trigger_test
